// File: hw/lfs_pkg.sv
package lfs_pkg;
   // Cycle counts at 100 MHz
   localparam int unsigned CLK_NS             = 10;
   localparam int unsigned SAMPLE_MS          = 1;
   localparam int unsigned SAMPLE_CYC_DEF     = SAMPLE_MS * 1000000 / CLK_NS;
   localparam int unsigned NEG_WINDOW_MS      = 10;
   localparam int unsigned NEG_WINDOW_SAMPLES = NEG_WINDOW_MS / SAMPLE_MS;
   localparam int unsigned POS_SLOPE_MS       = 2;
   localparam int unsigned POS_SLOPE_SAMPLES  = POS_SLOPE_MS / SAMPLE_MS;
   localparam int unsigned LINE_FAULT_CYC_DEF = 5000000;
   localparam int unsigned OV_BLANK_CYC_DEF   = 100;
   localparam int unsigned UNPLUG_CYC_DEF     = 2000000;
   localparam int unsigned OVP_FILT_CYC_DEF   = 100;
   localparam int unsigned OTP_FILT_CYC_DEF   = 100;
   localparam int unsigned OTP_BLANK_CYC_DEF  = 1000000;
   localparam int unsigned CNT_W              = 32;

   // Synchronised comparator levels
   typedef struct packed {
      logic line_low;
      logic line_high;
      logic line_ov;
      logic disch_end;
      logic slope;
      logic prot_ovp;
      logic prot_otp;
   } lfs_cmp_t;

   // Supply level events
   typedef struct packed {
      logic turn_on;
      logic reset_rise;
      logic off_mode_exit;
      logic skip_mode;
   } lfs_supply_t;

   // Fault status flags
   typedef struct packed {
      logic line_brownout;
      logic line_overvoltage_flag;
      logic discharging;
      logic ovp_fault;
      logic otp_fault;
      logic latched;
   } lfs_status_t;
endpackage

// File: hw/lfs_supervisor.sv
`timescale 1ns/100ps
// Operation
// - Line low longer than fault timer flags brown-out and stops driver pulses.
// - After line rises above high threshold, start waits for next supply turn-on.
// - Crossing below line low only starts the fault timer; short dropouts ride through.
// - Restart after stop needs positive slope detected over two sample periods.
// - Line over-voltage comparator is blanked; short excursions never flag a fault.
// - Qualified line OV flags and stops; when over, fault timer restarts then expires.
// - New line OV while fault timer runs pauses and then resets it.
// - Timer expiry after OV with line low waits for fresh brown-in.
// - Detected unplug enables discharge current through startup path.
// - Every accepted slope edge restarts unplug timer; expiry without one means DC input.
// - Negative slope edge counts only within 10 ms of last positive edge.
// - Discharge works in every mode and runs until discharge-end threshold.
// - During discharge switching stays terminated and startup is blocked.
// - Switch only inside protection window; stop after filter delay outside it.
// - Build option picks latch or auto-recovery separately for OVP and OTP.
// - During startup blanking ignore OTP and drive boosted sense current.
// - Protection enable set at supply reset rise and on resuming, not hysteretic OTP.
// - Temperature sense current is off whenever gate drivers stop switching, except during startup blanking.
// - Build option keeps protection monitoring active during skip mode.
// - Hysteretic OTP stops below low threshold, resumes above high threshold.
// - Restart from off-mode skips the over-temperature evaluation.
// - Latched state holds until supply reset or line re-plug detected.
module lfs_supervisor #(
   parameter int unsigned LINE_FAULT_CYC = lfs_pkg::LINE_FAULT_CYC_DEF,
   parameter int unsigned OV_BLANK_CYC   = lfs_pkg::OV_BLANK_CYC_DEF,
   parameter int unsigned UNPLUG_CYC     = lfs_pkg::UNPLUG_CYC_DEF,
   parameter int unsigned SAMPLE_CYC     = lfs_pkg::SAMPLE_CYC_DEF,
   parameter int unsigned OVP_FILT_CYC   = lfs_pkg::OVP_FILT_CYC_DEF,
   parameter int unsigned OTP_FILT_CYC   = lfs_pkg::OTP_FILT_CYC_DEF,
   parameter int unsigned OTP_BLANK_CYC  = lfs_pkg::OTP_BLANK_CYC_DEF,
   parameter bit          OVP_LATCH      = 1'b1,
   parameter bit          OTP_LATCH      = 1'b1,
   parameter bit          OTP_HYST       = 1'b0,
   parameter bit          SKIP_MONITOR   = 1'b0
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   // Comparator levels and supply events
   input  wire lfs_pkg::lfs_cmp_t   cmp_in,
   input  wire lfs_pkg::lfs_supply_t supply,
   // Auto-recovery timer done, from supply logic
   input  wire logic                recovery_done,
   // Controls and status
   output logic                     switch_en_r,
   output logic                     discharge_en_r,
   output logic                     protection_enable_r,
   output logic                     temp_sense_en_r,
   output logic                     temp_sense_boost_r,
   output logic                     recovery_start_r,
   output lfs_pkg::lfs_status_t     status_r
);
   localparam int unsigned W = lfs_pkg::CNT_W;

   // Two-flop synchronisers
   lfs_pkg::lfs_cmp_t s1_r, cs;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         s1_r <= '0;
         cs   <= '0;
      end
      else
      begin
         s1_r <= cmp_in;
         cs   <= s1_r;
      end

   // Slope edge and sample tick
   logic          slope_d_r;
   logic [W-1:0]  samp_r;
   logic          tick;
   logic          pos_edge;
   logic          neg_edge;
   assign tick     = (samp_r == W'(SAMPLE_CYC - 1));
   assign pos_edge = cs.slope & ~slope_d_r;
   assign neg_edge = ~cs.slope & slope_d_r;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         slope_d_r <= 1'b0;
         samp_r    <= '0;
      end
      else
      begin
         slope_d_r <= cs.slope;
         samp_r    <= tick ? '0 : samp_r + W'(1);
      end

   // Negative edges accepted only in window after positive edge
   logic [7:0] negwin_r;
   logic       edge_ok;
   assign edge_ok = pos_edge | (neg_edge && negwin_r != 8'h00);
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         negwin_r <= 8'h00;
      else if (pos_edge)
         negwin_r <= 8'(lfs_pkg::NEG_WINDOW_SAMPLES);
      else if (tick && negwin_r != 8'h00)
         negwin_r <= negwin_r - 8'h01;

   // Unplug timer and discharge control
   logic [W-1:0] unplug_r;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         unplug_r       <= '0;
         discharge_en_r <= 1'b0;
      end
      else
      begin
         if (edge_ok)
            unplug_r <= '0;
         else if (unplug_r != W'(UNPLUG_CYC))
            unplug_r <= unplug_r + W'(1);
         if (cs.disch_end)
            discharge_en_r <= 1'b0;
         else if (unplug_r == W'(UNPLUG_CYC - 1) && !edge_ok)
            discharge_en_r <= 1'b1;
      end

   // Positive slope seen over two sample periods
   logic [1:0] posrun_r;
   logic       pos_in_per_r;
   logic       slope_ok;
   assign slope_ok = (posrun_r == 2'(lfs_pkg::POS_SLOPE_SAMPLES));
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         posrun_r     <= 2'd0;
         pos_in_per_r <= 1'b0;
      end
      else if (!switch_en_r && tick)
      begin
         pos_in_per_r <= 1'b0;
         if (pos_in_per_r || pos_edge)
            posrun_r <= slope_ok ? posrun_r : posrun_r + 2'd1;
         else
            posrun_r <= 2'd0;
      end
      else
      begin
         pos_in_per_r <= pos_in_per_r | pos_edge;
         if (switch_en_r)
            posrun_r <= 2'd0;
      end

   // Line overvoltage blanking
   logic [W-1:0] ovb_r;
   logic         line_ov_q;
   assign line_ov_q = (ovb_r == W'(OV_BLANK_CYC));
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         ovb_r <= '0;
      else if (!cs.line_ov)
         ovb_r <= '0;
      else if (!line_ov_q)
         ovb_r <= ovb_r + W'(1);

   // Shared line fault timer, brown-out and line OV flags
   logic [W-1:0] lft_r;
   logic         bo_arm_r;
   logic         lft_done;
   assign lft_done = (lft_r == W'(LINE_FAULT_CYC));
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         lft_r    <= '0;
         bo_arm_r <= 1'b0;
         status_r.line_brownout         <= 1'b1;
         status_r.line_overvoltage_flag <= 1'b0;
      end
      else if (line_ov_q)
      begin
         status_r.line_overvoltage_flag <= 1'b1;
         lft_r    <= '0;
         bo_arm_r <= 1'b0;
      end
      else if (status_r.line_overvoltage_flag)
      begin
         if (cs.line_ov)
            lft_r <= lft_r;
         else if (!lft_done)
            lft_r <= lft_r + W'(1);
         else
         begin
            status_r.line_overvoltage_flag <= 1'b0;
            lft_r <= '0;
            if (cs.line_low)
               status_r.line_brownout <= 1'b1;
         end
      end
      else if (cs.line_high)
      begin
         status_r.line_brownout <= 1'b0;
         lft_r    <= '0;
         bo_arm_r <= 1'b0;
      end
      else if (cs.line_low && !status_r.line_brownout)
      begin
         bo_arm_r <= 1'b1;
         if (lft_done)
            status_r.line_brownout <= 1'b1;
         else
            lft_r <= lft_r + W'(1);
      end
      else if (bo_arm_r && !cs.line_low)
      begin
         bo_arm_r <= 1'b0;
         lft_r    <= '0;
      end

   // Brown-out and line OV keep the drivers stopped
   a_brownout_stops : assert property (
      @(posedge clk) disable iff (!rstn)
      status_r.line_brownout |=> !switch_en_r)
      else $error("switching during brown-out");
   a_line_ov_stops : assert property (
      @(posedge clk) disable iff (!rstn)
      status_r.line_overvoltage_flag |=> !switch_en_r)
      else $error("switching during line over-voltage");
   // Line OV flag only rises after a full blanking span
   a_line_ov_blanked : assert property (
      @(posedge clk) disable iff (!rstn)
      $rose(status_r.line_overvoltage_flag) |-> $past(line_ov_q))
      else $error("line over-voltage flagged without blanking");

   // Protection window filters
   logic [W-1:0] ovpf_r;
   logic [W-1:0] otpf_r;
   logic [W-1:0] blank_r;
   logic         monitor;
   logic         blanking;
   logic         ovp_q;
   logic         otp_q;
   logic         otp_skip_r;
   assign monitor  = protection_enable_r
                     && (!supply.skip_mode || SKIP_MONITOR);
   assign blanking = (blank_r != '0);
   assign ovp_q    = (ovpf_r == W'(OVP_FILT_CYC));
   assign otp_q    = (otpf_r == W'(OTP_FILT_CYC));
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         ovpf_r <= '0;
         otpf_r <= '0;
      end
      else
      begin
         if (!monitor || !cs.prot_ovp)
            ovpf_r <= '0;
         else if (!ovp_q)
            ovpf_r <= ovpf_r + W'(1);
         if (!monitor || !cs.prot_otp || blanking || otp_skip_r)
            otpf_r <= '0;
         else if (!otp_q)
            otpf_r <= otpf_r + W'(1);
      end

   // Startup temperature blanking and off-mode OTP skip
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         blank_r    <= '0;
         otp_skip_r <= 1'b0;
      end
      else
      begin
         if (supply.reset_rise)
            blank_r <= W'(OTP_BLANK_CYC);
         else if (blanking)
            blank_r <= blank_r - W'(1);
         if (supply.off_mode_exit)
            otp_skip_r <= 1'b1;
         else if (supply.reset_rise)
            otp_skip_r <= 1'b0;
      end

   // Startup blanking boosts the sense current and mutes OTP
   a_boost_in_blank : assert property (
      @(posedge clk) disable iff (!rstn)
      blanking |=> temp_sense_boost_r && otpf_r == '0)
      else $error("no boost or OTP not muted in blanking");
   // Sense current follows the drivers outside blanking
   a_sense_off_idle : assert property (
      @(posedge clk) disable iff (!rstn)
      !switch_en_r && !blanking |=> !temp_sense_en_r)
      else $error("temperature sense on while stopped");

   // Protection fault, latch and hysteretic OTP
   logic hyst_r;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         status_r.ovp_fault <= 1'b0;
         status_r.otp_fault <= 1'b0;
         status_r.latched   <= 1'b0;
         recovery_start_r   <= 1'b0;
         hyst_r             <= 1'b0;
      end
      else
      begin
         recovery_start_r <= 1'b0;
         // Clear first so a fresh hysteretic trip in the same cycle wins
         if (hyst_r && !cs.prot_otp)
            hyst_r <= 1'b0;
         if (supply.reset_rise || (status_r.latched && discharge_en_r))
         begin
            status_r.latched   <= 1'b0;
            status_r.ovp_fault <= 1'b0;
            status_r.otp_fault <= 1'b0;
         end
         else if (ovp_q && !status_r.ovp_fault)
         begin
            status_r.ovp_fault <= 1'b1;
            status_r.latched   <= status_r.latched | OVP_LATCH;
            recovery_start_r   <= !OVP_LATCH;
         end
         else if (otp_q && OTP_HYST)
            hyst_r <= 1'b1;
         else if (otp_q && !status_r.otp_fault)
         begin
            status_r.otp_fault <= 1'b1;
            status_r.latched   <= status_r.latched | OTP_LATCH;
            recovery_start_r   <= !OTP_LATCH;
         end
         else if (recovery_done && !status_r.latched)
         begin
            status_r.ovp_fault <= 1'b0;
            status_r.otp_fault <= 1'b0;
         end
      end

   // Latch holds until supply reset or re-plug cue
   a_latch_holds : assert property (
      @(posedge clk) disable iff (!rstn)
      status_r.latched && !supply.reset_rise && !discharge_en_r
      |=> status_r.latched)
      else $error("latch released without reset or re-plug");

   // Switching permission, protection enable and sense current
   logic run_ok;
   logic may_start_r;
   assign run_ok = !status_r.line_brownout
                   && !status_r.line_overvoltage_flag
                   && !discharge_en_r
                   && !status_r.ovp_fault && !status_r.otp_fault
                   && !status_r.latched && !hyst_r;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         switch_en_r         <= 1'b0;
         may_start_r         <= 1'b0;
         protection_enable_r <= 1'b0;
         temp_sense_en_r     <= 1'b0;
         temp_sense_boost_r  <= 1'b0;
         status_r.discharging <= 1'b0;
      end
      else
      begin
         status_r.discharging <= discharge_en_r;
         if (!run_ok)
            may_start_r <= 1'b0;
         else if (supply.turn_on && slope_ok)
            may_start_r <= 1'b1;
         if (!run_ok)
            switch_en_r <= 1'b0;
         else if (hyst_r == 1'b0 && switch_en_r == 1'b0 && may_start_r)
            switch_en_r <= 1'b1;
         if (supply.reset_rise)
            protection_enable_r <= 1'b1;
         else if (!switch_en_r && run_ok && may_start_r && !hyst_r)
            protection_enable_r <= 1'b1;
         temp_sense_en_r    <= switch_en_r || blanking;
         temp_sense_boost_r <= blanking;
      end

   a_discharge_stops : assert property (
      @(posedge clk) disable iff (!rstn)
      discharge_en_r |=> !switch_en_r)
      else $error("switching during discharge");
endmodule // lfs_supervisor

// File: verification/lfs_line_model.sv
`timescale 1ns/100ps
// Line sense and protection sensors, as seen through their comparators
module lfs_line_model #(
   parameter int unsigned SAMPLE_CYC = 20
) (
   // Clock
   input  wire logic              clk,
   // Scene chosen by the bench
   input  wire logic              ac_on,
   input  wire lfs_pkg::lfs_cmp_t scene,
   // Comparator levels
   output lfs_pkg::lfs_cmp_t      cmp
);
   int unsigned cnt_r   = 0;
   logic        slope_r = 1'b0;

   // Slope comparator pulses once a sample while AC is present, so every
   // sample holds one rising edge; with ac_on low (DC) the output
   // stays low
   always_ff @(posedge clk)
   begin
      cnt_r   <= (cnt_r + 1 >= SAMPLE_CYC) ? 0 : cnt_r + 1;
      slope_r <= ac_on && (cnt_r < SAMPLE_CYC / 2);
   end

   // Levels pass through, slope comes from the detector
   always_comb
   begin
      cmp       = scene;
      cmp.slope = slope_r;
   end
endmodule // lfs_line_model

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
   localparam int SC = 20;
   localparam int LF = 200;
   localparam int OB = 20;
   localparam int UN = 300;
   localparam int PF = 10;
   localparam int SW = 0, DIS = 1, BO = 2, OVF = 3, OVP = 4, LAT = 5;
   localparam int TS = 6, PE = 7;

   logic                clk = 1'b0;
   logic                rstn, ac_on, rec_done;
   lfs_pkg::lfs_cmp_t   scene, cmp;
   lfs_pkg::lfs_supply_t supply;
   logic                sw, dis, pe, ts, tb_boost, rec_start;
   lfs_pkg::lfs_status_t st;
   int                  fail_count = 0;
   int                  checks_done = 0;
   int                  len;

   lfs_line_model #(.SAMPLE_CYC(SC)) u_model (
      .clk(clk), .ac_on(ac_on), .scene(scene), .cmp(cmp));

   lfs_supervisor #(.LINE_FAULT_CYC(LF), .OV_BLANK_CYC(OB),
      .UNPLUG_CYC(UN), .SAMPLE_CYC(SC), .OVP_FILT_CYC(PF),
      .OTP_FILT_CYC(PF), .OTP_BLANK_CYC(100)) u_dut (
      .clk(clk), .rstn(rstn), .cmp_in(cmp), .supply(supply),
      .recovery_done(rec_done), .switch_en_r(sw),
      .discharge_en_r(dis), .protection_enable_r(pe),
      .temp_sense_en_r(ts), .temp_sense_boost_r(tb_boost),
      .recovery_start_r(rec_start), .status_r(st));

   // Clock generator
   initial
   begin
      forever #5 clk = ~clk;
   end

   // Picks one observed flag
   function automatic logic sig(input int s);
      case (s)
         SW: return sw;
         DIS: return dis;
         BO: return st.line_brownout;
         OVF: return st.line_overvoltage_flag;
         OVP: return st.ovp_fault;
         LAT: return st.latched;
         TS: return ts;
         default: return pe;
      endcase
   endfunction

   task automatic chk(input logic got, exp, input string m);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   // Bounded wait for a flag level, then compare
   task automatic wait_lv(input int s, input logic v, input int lim,
                          input string m);
      int i;
      i = 0;
      while (sig(s) !== v && i < lim)
      begin
         @(posedge clk);
         #1;
         i++;
      end
      chk(sig(s), v, m);
   endtask

   // Flag must keep its level for n cycles
   task automatic hold(input int s, input logic v, input int n,
                       input string m);
      repeat (n)
      begin
         @(posedge clk);
         #1;
         chk(sig(s), v, m);
      end
   endtask

   // One-cycle supply event
   task automatic pulse(input int b);
      @(posedge clk);
      supply[b] <= 1'b1;
      @(posedge clk);
      supply[b] <= 1'b0;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rstn  <= 1'b0;
      ac_on <= 1'b0;
      scene <= 7'b100_0000;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
   endtask

   // Line good, AC slope present, then the supply turn-on event
   task automatic start_up();
      @(posedge clk);
      scene.line_low  <= 1'b0;
      scene.line_high <= 1'b1;
      ac_on           <= 1'b1;
      pulse(2);
      hold(SW, 1'b0, 4 * SC, "start before turn-on");
      chk(pe, 1'b1, "protection not enabled");
      chk(tb_boost, 1'b1, "no boost in blanking");
      pulse(3);
      wait_lv(SW, 1'b1, 20, "no start");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog against a hang
   initial
   begin
      repeat (30000) @(posedge clk);
      fail_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      results();
   end

   initial
   begin
      rstn     = 1'b0;
      ac_on    = 1'b0;
      rec_done = 1'b0;
      scene    = 7'b100_0000;
      supply   = '0;
      void'($urandom(13568));
      // Reset state
      do_reset();
      #1;
      chk(sw, 1'b0, "switch after reset");
      chk(dis, 1'b0, "discharge after reset");
      chk(st.line_brownout, 1'b1, "brownout after reset");
      $display("test reset done");
      // Dropouts: short ones ride through, a long one stops
      start_up();
      repeat (4)
      begin
         len = 5 + ($urandom % (LF - 40));
         @(posedge clk);
         scene.line_low  <= 1'b1;
         scene.line_high <= 1'b0;
         hold(SW, 1'b1, len, "short dropout stopped");
         @(posedge clk);
         scene.line_low  <= 1'b0;
         scene.line_high <= 1'b1;
         hold(SW, 1'b1, 10, "after dropout");
      end
      @(posedge clk);
      scene.line_low  <= 1'b1;
      scene.line_high <= 1'b0;
      wait_lv(BO, 1'b1, LF + 10, "no brownout");
      hold(SW, 1'b0, 2, "switching in brownout");
      chk(ts, 1'b0, "temp sense while stopped");
      chk(tb_boost, 1'b0, "boost after blanking");
      $display("test brownout done");
      // Line over-voltage blanking and stop
      do_reset();
      start_up();
      len = 1 + ($urandom % (OB - 6));
      @(posedge clk);
      scene.line_ov <= 1'b1;
      hold(OVF, 1'b0, len, "short surge flagged");
      @(posedge clk);
      scene.line_ov <= 1'b0;
      hold(SW, 1'b1, 10, "short surge stopped");
      @(posedge clk);
      scene.line_ov <= 1'b1;
      wait_lv(OVF, 1'b1, OB + 10, "no line ov flag");
      hold(SW, 1'b0, 2, "switching in line ov");
      @(posedge clk);
      scene.line_ov <= 1'b0;
      hold(SW, 1'b0, LF / 2, "restart before timer");
      // A qualified surge mid-count must restart the timer from zero
      @(posedge clk);
      scene.line_ov <= 1'b1;
      hold(OVF, 1'b1, OB + 5, "flag lost in resurge");
      @(posedge clk);
      scene.line_ov <= 1'b0;
      hold(OVF, 1'b1, LF * 3 / 4, "timer not reset");
      wait_lv(OVF, 1'b0, LF, "line ov flag stuck");
      pulse(3);
      wait_lv(SW, 1'b1, 20, "no restart after line ov");
      $display("test line ov done");
      // Unplug detection and discharge
      do_reset();
      start_up();
      hold(DIS, 1'b0, UN + 20, "discharge with AC");
      @(posedge clk);
      ac_on <= 1'b0;
      wait_lv(DIS, 1'b1, UN + 2 * SC + 10, "no discharge");
      hold(SW, 1'b0, 2, "switching in discharge");
      chk(ts, 1'b0, "temp sense in discharge");
      pulse(3);
      hold(SW, 1'b0, 20, "start in discharge");
      @(posedge clk);
      scene.disch_end <= 1'b1;
      wait_lv(DIS, 1'b0, 20, "discharge not ended");
      $display("test unplug done");
      // Protection window, latch and release
      do_reset();
      start_up();
      @(posedge clk);
      scene.prot_ovp <= 1'b1;
      hold(SW, 1'b1, PF - 6, "filter too short");
      @(posedge clk);
      scene.prot_ovp <= 1'b0;
      hold(SW, 1'b1, 10, "glitch stopped");
      @(posedge clk);
      scene.prot_ovp <= 1'b1;
      wait_lv(OVP, 1'b1, PF + 10, "no ovp fault");
      chk(rec_start, 1'b0, "recovery in latched build");
      hold(SW, 1'b0, 2, "switching in ovp");
      chk(st.latched, 1'b1, "not latched");
      @(posedge clk);
      scene.prot_ovp <= 1'b0;
      pulse(3);
      hold(SW, 1'b0, 20, "latch left by turn-on");
      pulse(2);
      wait_lv(LAT, 1'b0, 10, "latch not released");
      $display("test protection done");
      results();
   end
endmodule // tb
